// file: qtxc_pkg.sv
package qtxc_pkg;
    // register map, 16-bit registers at their byte offsets
    localparam logic [8:0]  QTXC_CTRL_OFS    = 9'h170;
    localparam logic [8:0]  QTXC_STAT_OFS    = 9'h172;
    // control field positions
    localparam int          QTXC_ICMP_BIT    = 8;
    localparam int          QTXC_UDP_BIT     = 7;
    localparam int          QTXC_TCP_BIT     = 6;
    localparam int          QTXC_IP_BIT      = 5;
    localparam int          QTXC_FLUSH_BIT   = 4;
    localparam int          QTXC_FC_BIT      = 3;
    localparam int          QTXC_PAD_BIT     = 2;
    localparam int          QTXC_FCS_BIT     = 1;
    localparam int          QTXC_RUN_BIT     = 0;
    localparam logic [8:0]  QTXC_CTRL_RST    = 9'h000;
    // status field positions
    localparam int          QTXC_LATE_BIT    = 13;
    localparam int          QTXC_MAXC_BIT    = 12;
    localparam int          QTXC_ID_W        = 6;
    localparam logic [15:0] QTXC_STAT_RST    = 16'h0000;
    // frame shaping: minimum frame includes the 4-byte check sequence
    localparam logic [6:0]  QTXC_MIN_FRAME   = 7'h40;
    localparam logic [6:0]  QTXC_FCS_BYTES   = 7'h04;
    localparam logic [31:0] QTXC_CRC_INIT    = 32'hffffffff;
    localparam logic [31:0] QTXC_CRC_POLY    = 32'hedb88320;
    typedef enum logic [1:0] {QTXC_IDLE, QTXC_DATA, QTXC_PAD, QTXC_FCS} qtxc_state_type;
endpackage

// file: qtxc_queue_tx_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module qtxc_queue_tx_ctrl
    import qtxc_pkg::*;
#(
    parameter int LEVEL_W = 12,
    parameter logic [11:0] PAUSE_THRESH = 12'hc00
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_b_in,
    input  wire logic [8:0]         reg_addr_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    input  wire logic [1:0]         reg_be_in,
    input  wire logic [15:0]        reg_wdata_in,
    output logic      [15:0]        reg_rdata_out,
    input  wire logic               in_valid_in,
    input  wire logic [7:0]         in_data_in,
    input  wire logic               in_last_in,
    output logic                    in_ready_out,
    output logic                    out_valid_out,
    output logic      [7:0]         out_data_out,
    output logic                    out_last_out,
    input  wire logic               out_ready_in,
    output logic      [3:0]         csum_gen_en_out,
    output logic                    tx_running_out,
    output logic      [5:0]         frame_ptr_out,
    input  wire logic               full_duplex_in,
    input  wire logic [LEVEL_W-1:0] rx_level_in,
    output logic                    pause_req_out,
    output logic                    backpressure_out,
    input  wire logic               tx_done_in,
    input  wire logic               late_col_in,
    input  wire logic               max_col_in,
    input  wire logic [5:0]         done_id_in
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [8:0]     ctrl_reg;
    logic [15:0]    stat_reg;
    qtxc_state_type state_reg;
    logic           hold_v_reg;
    logic [7:0]     hold_d_reg;
    logic           hold_l_reg;
    logic           skid_v_reg;
    logic [7:0]     skid_d_reg;
    logic           skid_l_reg;
    logic [31:0]    crc_reg;
    logic [6:0]     cnt_reg;
    logic [1:0]     fcs_idx_reg;
    logic           opt_pad_reg;
    logic           opt_fcs_reg;
    logic           above_reg;
    logic           push;
    logic [7:0]     push_d;
    logic           push_l;
    logic           consume;
    logic           flush;
    logic           run;
    logic           pad_short;
    logic [31:0]    crc_inv;
    assign flush = ctrl_reg[QTXC_FLUSH_BIT];
    assign run   = ctrl_reg[QTXC_RUN_BIT];
    assign crc_inv = ~crc_reg;
    // byte-wise reflected crc step
    function automatic logic [31:0] qtxc_crc8(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ QTXC_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    // control writes; status offset is decoded but never written
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ctrl_reg <= QTXC_CTRL_RST;
        end else if (reg_wr_in && reg_addr_in == QTXC_CTRL_OFS) begin
            if (reg_be_in[0]) begin
                ctrl_reg[7:0] <= reg_wdata_in[7:0];
            end
            if (reg_be_in[1]) begin
                ctrl_reg[8] <= reg_wdata_in[8];
            end
        end
    end
    // registered read data, reserved bits zero
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            if (reg_addr_in == QTXC_CTRL_OFS) begin
                reg_rdata_out <= {7'h00, ctrl_reg};
            end else if (reg_addr_in == QTXC_STAT_OFS) begin
                reg_rdata_out <= stat_reg;
            end else begin
                reg_rdata_out <= 16'h0000;
            end
        end
    end
    // status of the last finished frame overwrites the previous one
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            stat_reg <= QTXC_STAT_RST;
        end else if (tx_done_in) begin
            stat_reg <= '0;
            stat_reg[QTXC_LATE_BIT] <= late_col_in;
            stat_reg[QTXC_MAXC_BIT] <= max_col_in;
            stat_reg[QTXC_ID_W-1:0] <= done_id_in;
        end
    end
    // ------------------------------------------------------------
    // input holding stage
    // ------------------------------------------------------------
    // one byte held so in_ready can come from a flop; costs half rate
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || flush) begin
            hold_v_reg   <= 1'b0;
            in_ready_out <= 1'b0;
        end else begin
            if (in_valid_in && in_ready_out) begin
                hold_v_reg <= 1'b1;
                hold_d_reg <= in_data_in;
                hold_l_reg <= in_last_in;
            end else if (consume) begin
                hold_v_reg <= 1'b0;
            end
            in_ready_out <= !(in_valid_in && in_ready_out) && (consume || !hold_v_reg);
        end
    end
    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    assign pad_short = opt_pad_reg && (cnt_reg < QTXC_MIN_FRAME - QTXC_FCS_BYTES - 7'h01);  // no wrap at 7f
    // choose the byte pushed into the output buffer this cycle
    always_comb begin
        push    = 1'b0;
        push_d  = 8'h00;
        push_l  = 1'b0;
        consume = 1'b0;
        case (state_reg)
            QTXC_DATA: begin
                if (hold_v_reg && !skid_v_reg) begin
                    push    = 1'b1;
                    consume = 1'b1;
                    push_d  = hold_d_reg;
                    push_l  = hold_l_reg && !pad_short && !opt_fcs_reg;
                end
            end
            QTXC_PAD: begin
                push   = !skid_v_reg;
                push_l = !pad_short && !opt_fcs_reg;
            end
            QTXC_FCS: begin
                push   = !skid_v_reg;
                push_d = crc_inv[{fcs_idx_reg, 3'h0} +: 8];
                push_l = fcs_idx_reg == 2'h3;
            end
            default: begin
            end
        endcase
    end
    // frame sequencing; stop only takes effect between frames
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || flush) begin
            state_reg     <= QTXC_IDLE;
            frame_ptr_out <= 6'h00;
            cnt_reg       <= 7'h00;
            fcs_idx_reg   <= 2'h0;
            crc_reg       <= QTXC_CRC_INIT;
            opt_pad_reg   <= 1'b0;
            opt_fcs_reg   <= 1'b0;
            csum_gen_en_out <= 4'h0;
        end else begin
            case (state_reg)
                QTXC_IDLE: begin
                    if (run && hold_v_reg) begin
                        state_reg   <= QTXC_DATA;
                        cnt_reg     <= 7'h00;
                        fcs_idx_reg <= 2'h0;
                        crc_reg     <= QTXC_CRC_INIT;
                        opt_pad_reg <= ctrl_reg[QTXC_PAD_BIT];
                        opt_fcs_reg <= ctrl_reg[QTXC_FCS_BIT];
                        frame_ptr_out <= frame_ptr_out + 6'h01;
                        // per-frame enables for the downstream checksum inserter
                        csum_gen_en_out <= {ctrl_reg[QTXC_ICMP_BIT],
                                            ctrl_reg[QTXC_UDP_BIT],
                                            ctrl_reg[QTXC_TCP_BIT],
                                            ctrl_reg[QTXC_IP_BIT]};
                    end
                end
                QTXC_DATA, QTXC_PAD: begin
                    if (push) begin
                        crc_reg <= qtxc_crc8(crc_reg, push_d);
                        cnt_reg <= (cnt_reg == 7'h7f) ? cnt_reg : cnt_reg + 7'h01;  // saturates, no wrap
                        if (state_reg == QTXC_PAD || hold_l_reg) begin
                            if (pad_short) begin
                                state_reg <= QTXC_PAD;
                            end else if (opt_fcs_reg) begin
                                state_reg <= QTXC_FCS;
                            end else begin
                                state_reg <= QTXC_IDLE;
                            end
                        end
                    end
                end
                QTXC_FCS: begin
                    if (push) begin
                        fcs_idx_reg <= fcs_idx_reg + 2'h1;
                        if (push_l) begin
                            state_reg <= QTXC_IDLE;
                        end
                    end
                end
                default: state_reg <= QTXC_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // two-entry output buffer
    // ------------------------------------------------------------
    // the skid entry catches the pushed byte when the receiver stalls
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || flush) begin
            out_valid_out <= 1'b0;
            skid_v_reg    <= 1'b0;
            out_data_out  <= 8'h00;
            out_last_out  <= 1'b0;
        end else if (!out_valid_out || out_ready_in) begin
            if (skid_v_reg) begin
                out_data_out <= skid_d_reg;
                out_last_out <= skid_l_reg;
                skid_v_reg   <= 1'b0;
            end else begin
                out_valid_out <= push;
                out_data_out  <= push_d;
                out_last_out  <= push_l;
            end
        end else if (push) begin
            skid_v_reg <= 1'b1;
            skid_d_reg <= push_d;
            skid_l_reg <= push_l;
        end
    end
    // run state seen by the host side: enabled or still finishing a frame
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            tx_running_out <= 1'b0;
        end else begin
            tx_running_out <= run || state_reg != QTXC_IDLE;
        end
    end
    // ------------------------------------------------------------
    // flow control
    // ------------------------------------------------------------
    // pause is one request per threshold crossing, not a stream
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            above_reg        <= 1'b0;
            pause_req_out    <= 1'b0;
            backpressure_out <= 1'b0;
        end else begin
            above_reg        <= rx_level_in >= PAUSE_THRESH;
            pause_req_out    <= ctrl_reg[QTXC_FC_BIT] && full_duplex_in
                                && rx_level_in >= PAUSE_THRESH && !above_reg;
            backpressure_out <= ctrl_reg[QTXC_FC_BIT] && !full_duplex_in
                                && rx_level_in >= PAUSE_THRESH;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_rst_ctrl;
        @(posedge ref_clk_in) !rst_b_in |=> ctrl_reg == 9'h000;
    endproperty
    a_rst_ctrl: assert property (p_rst_ctrl) else $error("control not cleared by reset");
    property p_stat_id;
        @(posedge ref_clk_in) disable iff (!rst_b_in) tx_done_in |=> stat_reg[5:0] == $past(done_id_in);
    endproperty
    a_stat_id: assert property (p_stat_id) else $error("frame id not captured");
    property p_late;
        @(posedge ref_clk_in) disable iff (!rst_b_in) tx_done_in |=> stat_reg[13] == $past(late_col_in);
    endproperty
    a_late: assert property (p_late) else $error("late collision flag wrong");
    property p_maxc;
        @(posedge ref_clk_in) disable iff (!rst_b_in) tx_done_in ##1 !tx_done_in |=> $stable(stat_reg[12]);
    endproperty
    a_maxc: assert property (p_maxc) else $error("max collision flag changed without frame");
    property p_bp;
        @(posedge ref_clk_in) disable iff (!rst_b_in) backpressure_out |-> $past(!full_duplex_in && ctrl_reg[3]);
    endproperty
    a_bp: assert property (p_bp) else $error("back-pressure without half duplex flow control");
    property p_pause;
        @(posedge ref_clk_in) disable iff (!rst_b_in) pause_req_out |-> $past(full_duplex_in && ctrl_reg[3]) ##1 !pause_req_out;
    endproperty
    a_pause: assert property (p_pause) else $error("pause request not a single flow control pulse");
    sequence s_flush_set;
        flush;
    endsequence
    sequence s_cleared;
        state_reg == QTXC_IDLE && !out_valid_out && !hold_v_reg && frame_ptr_out == 6'h00;
    endsequence
    property p_flush;
        @(posedge ref_clk_in) disable iff (!rst_b_in) s_flush_set |=> s_cleared;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left queue state");
    property p_start;
        @(posedge ref_clk_in) disable iff (!rst_b_in) state_reg == QTXC_IDLE ##1 state_reg == QTXC_DATA |-> $past(run);
    endproperty
    a_start: assert property (p_start) else $error("frame started while stopped");
    property p_pad;
        @(posedge ref_clk_in) disable iff (!rst_b_in) state_reg == QTXC_PAD && push && !pad_short |-> cnt_reg == 7'h3b;
    endproperty
    a_pad: assert property (p_pad) else $error("padded frame ended at wrong length");
endmodule
`default_nettype wire

// file: qtxc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// host processor model on the parallel register port
// ------------------------------------------------------------
module qtxc_host_model
    import qtxc_pkg::*;
(
    input  wire logic        ref_clk_in,
    output logic      [8:0]  reg_addr_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    output logic      [1:0]  reg_be_out,
    output logic      [15:0] reg_wdata_out,
    input  wire logic [15:0] reg_rdata_in
);
    // idle bus at time zero
    initial begin
        reg_addr_out  = 9'h000;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        reg_be_out    = 2'h3;
        reg_wdata_out = 16'h0000;
    end

    // one write; the strobe stands for exactly one sampling edge
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_wr_out    <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_out    <= 1'b0;
    endtask

    // one read; data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_out <= a;
        reg_rd_out   <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_out   <= 1'b0;
        @(posedge ref_clk_in);
        #1 d = reg_rdata_in;
    endtask

    // padding is never enabled without the check sequence append
    task automatic cfg(input logic [15:0] d);
        logic [15:0] v;
        v = d;
        v[QTXC_FCS_BIT] = d[QTXC_FCS_BIT] | d[QTXC_PAD_BIT];
        wr(QTXC_CTRL_OFS, v);
    endtask

    // stop the transmitter first, pulse the flush, then release it
    task automatic flush(input logic [15:0] d);
        logic [15:0] v;
        v = d & 16'hfffe;
        wr(QTXC_CTRL_OFS, v);
        wr(QTXC_CTRL_OFS, v | 16'h0010);
        wr(QTXC_CTRL_OFS, v);
    endtask
endmodule
`default_nettype wire

// file: qtxc_queue_tx_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module qtxc_queue_tx_ctrl_tb
    import qtxc_pkg::*;
;
    localparam logic [11:0] TH = 12'h100;
    localparam logic [15:0] CT [5] = '{16'h01e7, 16'h0147, 16'h00a3, 16'h0001, 16'h0003};
    localparam int          LN [5] = '{1, 60, 3, 2, 20};
    localparam logic [3:0]  CS [5] = '{4'hf, 4'ha, 4'h5, 4'h0, 4'h0};
    logic        ref_clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [8:0]  reg_addr;
    logic        reg_wr, reg_rd;
    logic [1:0]  reg_be;
    logic [15:0] reg_wdata, reg_rdata_out, v;
    logic        in_valid_in = 1'b0, in_last_in = 1'b0, in_ready_out;
    logic [7:0]  in_data_in = 8'h00, out_data_out;
    logic        out_valid_out, out_last_out, out_ready_in = 1'b0;
    logic [3:0]  csum_gen_en_out;
    logic        tx_running_out, pause_req_out, backpressure_out;
    logic [5:0]  frame_ptr_out, done_id_in = 6'h00;
    logic        full_duplex_in = 1'b0, tx_done_in = 1'b0, late_col_in = 1'b0, max_col_in = 1'b0;
    logic [11:0] rx_level_in = 12'h000;
    logic [7:0]  stall_cnt = 8'h00;
    logic [7:0]  got [$];
    int          last_at, pauses, errors, comparisons;

    qtxc_host_model i_qtxc_host_model (.ref_clk_in(ref_clk_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
        .reg_rd_out(reg_rd), .reg_be_out(reg_be), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata_out));

    qtxc_queue_tx_ctrl #(.LEVEL_W(12), .PAUSE_THRESH(TH)) i_qtxc_queue_tx_ctrl (.ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_be_in(reg_be),
        .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata_out), .in_valid_in(in_valid_in),
        .in_data_in(in_data_in), .in_last_in(in_last_in), .in_ready_out(in_ready_out),
        .out_valid_out(out_valid_out), .out_data_out(out_data_out), .out_last_out(out_last_out),
        .out_ready_in(out_ready_in), .csum_gen_en_out(csum_gen_en_out), .tx_running_out(tx_running_out),
        .frame_ptr_out(frame_ptr_out), .full_duplex_in(full_duplex_in), .rx_level_in(rx_level_in),
        .pause_req_out(pause_req_out), .backpressure_out(backpressure_out), .tx_done_in(tx_done_in),
        .late_col_in(late_col_in), .max_col_in(max_col_in), .done_id_in(done_id_in));

    // ------------------------------------------------------------
    // clock, stalling sink and monitors
    // ------------------------------------------------------------
    always #2 ref_clk_in = ~ref_clk_in;

    // sink stalls often and sometimes long, so the output buffer fills up
    always @(posedge ref_clk_in) begin
        stall_cnt    <= stall_cnt + 8'h01;
        out_ready_in <= (stall_cnt[5:3] != 3'h0) && (stall_cnt[1:0] != 2'h3);
    end

    always @(posedge ref_clk_in) begin
        if (out_valid_out === 1'b1 && out_ready_in === 1'b1) begin
            got.push_back(out_data_out);
            if (out_last_out === 1'b1) last_at = got.size();
        end
        if (pause_req_out === 1'b1) pauses++;
    end

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // reflected crc, computed independently of the design
    function automatic logic [31:0] crc32(input logic [7:0] q [$]);
        logic [31:0] c;
        c = QTXC_CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {24'h000000, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ QTXC_CRC_POLY) : (c >> 1);
        end
        return ~c;
    endfunction

    task automatic send(input int n);
        int k;
        @(posedge ref_clk_in);
        for (int i = 0; i < n; i++) begin
            in_valid_in <= 1'b1;
            in_data_in  <= 8'h10 + 8'(i);
            in_last_in  <= (i == n - 1);
            k = 0;
            do begin
                @(posedge ref_clk_in);
                k++;
            end while (in_ready_out !== 1'b1 && k < 200);
        end
        in_valid_in <= 1'b0;
        in_last_in  <= 1'b0;
    endtask

    task automatic status(input logic [5:0] id, input logic lc, input logic mc);
        @(posedge ref_clk_in);
        tx_done_in  <= 1'b1;
        done_id_in  <= id;
        late_col_in <= lc;
        max_col_in  <= mc;
        @(posedge ref_clk_in);
        tx_done_in  <= 1'b0;
        i_qtxc_host_model.rd(QTXC_STAT_OFS, v);
    endtask

    // one frame under one control word; the last entry drops run mid-frame
    task automatic run_frame(input int t);
        logic [7:0]  e [$];
        logic [31:0] crc;
        int          m;
        m = 0;
        got.delete();
        last_at = 0;
        for (int i = 0; i < LN[t]; i++) e.push_back(8'h10 + 8'(i));
        while (CT[t][QTXC_PAD_BIT] && e.size() < 60) e.push_back(8'h00);
        crc = crc32(e);
        for (int i = 0; i < 4 && CT[t][QTXC_FCS_BIT]; i++) e.push_back(crc[8*i +: 8]);
        i_qtxc_host_model.cfg(CT[t]);
        repeat (2) @(posedge ref_clk_in);  // run reaches tx_running one edge after the write
        chk(16'(tx_running_out), 16'h0001);
        fork
            send(LN[t]);
            if (t == 4) begin
                repeat (8) @(posedge ref_clk_in);
                i_qtxc_host_model.wr(QTXC_CTRL_OFS, 16'h0002);
            end
        join
        while (last_at == 0 && m < 1000) begin
            @(posedge ref_clk_in);
            m++;
        end
        repeat (4) @(posedge ref_clk_in);
        chk(16'(got.size()), 16'(e.size()));
        chk(16'(last_at), 16'(e.size()));
        foreach (e[i]) if (i < got.size()) chk({8'h00, got[i]}, {8'h00, e[i]});
        chk({12'h000, csum_gen_en_out}, {12'h000, CS[t]});
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        i_qtxc_host_model.rd(QTXC_CTRL_OFS, v);
        chk(v, 16'h0000);
        chk({pause_req_out, backpressure_out, tx_running_out, frame_ptr_out}, 16'h0000);
        i_qtxc_host_model.wr(QTXC_CTRL_OFS, 16'hffee);
        i_qtxc_host_model.rd(QTXC_CTRL_OFS, v);
        chk(v, 16'h01ee);
        // upper byte lane only: bit 8 cleared, low byte kept
        i_qtxc_host_model.reg_be_out <= 2'h2;
        i_qtxc_host_model.wr(QTXC_CTRL_OFS, 16'h0000);
        i_qtxc_host_model.rd(QTXC_CTRL_OFS, v);
        chk(v, 16'h00ee);
        i_qtxc_host_model.reg_be_out <= 2'h3;
        i_qtxc_host_model.rd(9'h174, v);
        chk(v, 16'h0000);
        status(6'h05, 1'b1, 1'b0);
        chk(v, 16'h2005);
        status(6'h3f, 1'b0, 1'b1);
        chk(v, 16'h103f);
        i_qtxc_host_model.wr(QTXC_STAT_OFS, 16'hffff);
        i_qtxc_host_model.rd(QTXC_STAT_OFS, v);
        chk(v, 16'h103f);
        for (int t = 0; t < 5; t++) run_frame(t);
        chk(16'(tx_running_out), 16'h0000);
        chk(16'(frame_ptr_out), 16'h0005);
        // stopped and idle: an offered byte is taken into the holding stage but never sent, and in_ready drops
        in_valid_in <= 1'b1;
        got.delete();
        repeat (20) @(posedge ref_clk_in);
        chk({in_ready_out, 15'(got.size())}, 16'h0000);
        in_valid_in <= 1'b0;
        i_qtxc_host_model.flush(16'h0002);
        repeat (2) @(posedge ref_clk_in);
        chk(16'(frame_ptr_out), 16'h0000);
        // flow control: crossing in full duplex pulses once, half duplex holds a level
        i_qtxc_host_model.cfg(16'h0008);
        full_duplex_in <= 1'b1;
        rx_level_in    <= TH - 12'h001;
        repeat (4) @(posedge ref_clk_in);
        pauses = 0;
        rx_level_in <= TH;
        repeat (8) @(posedge ref_clk_in);
        chk(16'(pauses), 16'h0001);
        chk(16'(backpressure_out), 16'h0000);
        full_duplex_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        chk(16'(backpressure_out), 16'h0001);
        rx_level_in <= TH - 12'h001;
        repeat (4) @(posedge ref_clk_in);
        chk(16'(backpressure_out), 16'h0000);
        i_qtxc_host_model.cfg(16'h0000);
        rx_level_in <= TH;
        repeat (4) @(posedge ref_clk_in);
        chk(16'(backpressure_out), 16'h0000);
        full_duplex_in <= 1'b1;
        rx_level_in    <= 12'h000;
        repeat (4) @(posedge ref_clk_in);
        rx_level_in <= TH;
        repeat (8) @(posedge ref_clk_in);
        chk(16'(pauses), 16'h0001);
        wrap_up();
    end
endmodule
`default_nettype wire
